// [src/dpm_pkg.sv]
// constants, lane masks, field positions and state codes of the pixel mapper
// assumes every pin input is synchronised before any of these fields is used
// What this block does
// - one-port mode drives lane data on first four serial lanes only
// - two-port mode uses all eight lanes; port one keeps one-port mapping
// - red bits 0..7 come from input bits 4..11 on secondary edge
// - green 0..3 from primary bits 8..11, green 4..7 secondary bits 0..3
// - blue bits 0..7 come from input bits 0..7 on primary edge
// - outputs grouped by colour, pixel one or two, lane bit 0..7
// - colour lsb lands on lane bit 6, colour msb on lane bit 5
// - colour bits 2..7 to lane bits 0..5, bits 0,1 to lane 6,7
// - lower pixel half on primary edge, upper half on next secondary edge
// - edge order 0 makes rising edge primary, 1 falling; default 1
// - bus width 0 one 12-bit port, 1 two ports; default 0
package dpm_pkg;
  localparam int PORT_W = 12;
  localparam int IN_W = 24;
  localparam int COL_W = 8;
  // reset values of the configuration pins
  localparam logic EDGE_ORDER_RST = 1'b1;
  localparam logic BUS_WIDTH_RST = 1'b0;
  localparam logic DC_BAL_RST = 1'b0;
  localparam logic LINK_CLK_RST = 1'b0;
  // lane enable masks
  localparam logic [7:0] LANES_ONE_PORT = 8'h0F;
  localparam logic [7:0] LANES_TWO_PORT = 8'hFF;
  // field positions inside the 24-bit captured words
  localparam int RED_POS = 4;
  localparam int GRN_LO_POS = 8;
  localparam int GRN_HI_POS = 0;
  localparam int BLU_POS = 0;
  localparam int P2_RED_POS = 16;
  localparam int P2_GRN_LO_POS = 20;
  localparam int P2_GRN_HI_POS = 12;
  localparam int P2_BLU_POS = 12;
  typedef enum logic [0:0] {
    ST_WAIT_PRI = 1'b0,
    ST_WAIT_SEC = 1'b1
  } dpm_state_e;
endpackage

// [src/dpm_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes d comes from outside the clk domain
`timescale 1ns/1ps
module dpm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // a bit counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      q <= RST;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// [src/dpm_mapper.sv]
// double-pumped pixel capture and lane-bit mapping, top level
// assumes host clock well below clk/4 and data stable around each host edge
`timescale 1ns/1ps
module dpm_mapper
  import dpm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pixel_clk_in,
  input wire logic [IN_W-1:0] pixel_input_bits,
  input wire logic edge_order_pin,
  input wire logic bus_width_setting,
  input wire logic dc_balance_select,
  output logic [COL_W-1:0] px1_red,
  output logic [COL_W-1:0] px1_green,
  output logic [COL_W-1:0] px1_blue,
  output logic [COL_W-1:0] px2_red,
  output logic [COL_W-1:0] px2_green,
  output logic [COL_W-1:0] px2_blue,
  output logic [7:0] lane_enable,
  output logic dc_balance_out,
  output logic pix_valid
);
  // colour bit c to lane bit: c2..c7 -> 0..5, c0 -> 6, c1 -> 7
  function automatic logic [7:0] lane_map(input logic [7:0] c);
    lane_map = {c[1], c[0], c[7:2]};
  endfunction

  logic link_clk_q;
  logic link_clk_prev_reg;
  logic [IN_W-1:0] data_q;
  logic [2:0] cfg_q;
  logic edge_order;
  logic two_port;
  logic rise;
  logic fall;
  logic pri_edge;
  logic sec_edge;
  logic take_pair;
  logic [IN_W-1:0] lo_reg;
  logic [IN_W-1:0] hi_reg;
  logic two_port_reg;
  dpm_state_e state_reg;
  dpm_state_e state_next;

  // clock and data share one delay so edges and bits stay aligned
  dpm_sync #(.W(1), .RST(LINK_CLK_RST)) u_clk_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pixel_clk_in),
    .q(link_clk_q)
  );
  dpm_sync #(.W(IN_W), .RST('0)) u_data_sync (
    .clk(clk),
    .nrst(nrst),
    .d(pixel_input_bits),
    .q(data_q)
  );
  dpm_sync #(
    .W(3),
    .RST({DC_BAL_RST, BUS_WIDTH_RST, EDGE_ORDER_RST})
  ) u_cfg_sync (
    .clk(clk),
    .nrst(nrst),
    .d({dc_balance_select, bus_width_setting, edge_order_pin}),
    .q(cfg_q)
  );

  // edge finding on the filtered host clock
  assign edge_order = cfg_q[0];
  assign two_port = cfg_q[1];
  assign rise = link_clk_q & ~link_clk_prev_reg;
  assign fall = ~link_clk_q & link_clk_prev_reg;
  assign pri_edge = edge_order ? fall : rise;
  assign sec_edge = edge_order ? rise : fall;
  // a secondary edge without its primary is dropped, never half-assembled
  assign take_pair = sec_edge && (state_reg == ST_WAIT_SEC);

  // wait for primary, then for the secondary of the same period
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT_PRI: begin
        if (pri_edge) begin
          state_next = ST_WAIT_SEC;
        end
      end
      ST_WAIT_SEC: begin
        if (sec_edge) begin
          state_next = ST_WAIT_PRI;
        end
      end
      default: begin
        state_next = ST_WAIT_PRI;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_WAIT_PRI;
      link_clk_prev_reg <= LINK_CLK_RST;
    end else begin
      state_reg <= state_next;
      link_clk_prev_reg <= link_clk_q;
    end
  end

  // capture the two half-words of the period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lo_reg <= '0;
      hi_reg <= '0;
    end else begin
      if (pri_edge) begin
        lo_reg <= data_q;
      end
      if (take_pair) begin
        hi_reg <= data_q;
      end
    end
  end

  // lane-labelled colour words, formed from lo_reg and the live data_q of the secondary edge
  logic [7:0] p1_r;
  logic [7:0] p1_g;
  logic [7:0] p1_b;
  logic [7:0] p2_r;
  logic [7:0] p2_g;
  logic [7:0] p2_b;
  assign p1_r = lane_map(data_q[RED_POS +: 8]);
  assign p1_g = lane_map({data_q[GRN_HI_POS +: 4],
                          lo_reg[GRN_LO_POS +: 4]});
  assign p1_b = lane_map(lo_reg[BLU_POS +: 8]);
  assign p2_r = lane_map(data_q[P2_RED_POS +: 8]);
  assign p2_g = lane_map({data_q[P2_GRN_HI_POS +: 4],
                          lo_reg[P2_GRN_LO_POS +: 4]});
  assign p2_b = lane_map(lo_reg[P2_BLU_POS +: 8]);

  // one presentation per host period; unused second pixel held at zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      px1_red <= '0;
      px1_green <= '0;
      px1_blue <= '0;
      px2_red <= '0;
      px2_green <= '0;
      px2_blue <= '0;
      lane_enable <= LANES_ONE_PORT;
      dc_balance_out <= DC_BAL_RST;
      two_port_reg <= BUS_WIDTH_RST;
      pix_valid <= 1'b0;
    end else begin
      pix_valid <= take_pair;
      if (take_pair) begin
        two_port_reg <= two_port;
        dc_balance_out <= cfg_q[2];
        px1_red <= p1_r;
        px1_green <= p1_g;
        px1_blue <= p1_b;
        px2_red <= two_port ? p2_r : 8'h00;
        px2_green <= two_port ? p2_g : 8'h00;
        px2_blue <= two_port ? p2_b : 8'h00;
        // lane mask ignores dc balance selection
        lane_enable <= two_port ? LANES_TWO_PORT : LANES_ONE_PORT;
      end
    end
  end

  // checks
  property p_one_port_lanes;
    @(posedge clk) disable iff (!nrst)
      pix_valid && !two_port_reg |-> lane_enable == 8'h0F && px2_red == 8'h00;
  endproperty
  a_one_port_lanes: assert property (p_one_port_lanes)
    else $error("one-port mode uses lanes beyond the first four");
  property p_two_port_lanes;
    @(posedge clk) disable iff (!nrst)
      pix_valid && two_port_reg |-> lane_enable == 8'hFF
        && px2_blue == {lo_reg[13:12], lo_reg[19:14]};
  endproperty
  a_two_port_lanes: assert property (p_two_port_lanes)
    else $error("two-port mode lanes or second pixel wrong");
  property p_red_map;
    @(posedge clk) disable iff (!nrst)
      pix_valid |-> px1_red == {hi_reg[5:4], hi_reg[11:6]};
  endproperty
  a_red_map: assert property (p_red_map)
    else $error("red taken from wrong input bits");
  property p_green_map;
    @(posedge clk) disable iff (!nrst)
      pix_valid |-> px1_green == {lo_reg[9:8], hi_reg[3:0], lo_reg[11:10]};
  endproperty
  a_green_map: assert property (p_green_map)
    else $error("green taken from wrong input bits");
  property p_blue_map;
    @(posedge clk) disable iff (!nrst)
      pix_valid |-> px1_blue == {lo_reg[1:0], lo_reg[7:2]};
  endproperty
  a_blue_map: assert property (p_blue_map)
    else $error("blue taken from wrong input bits");
  property p_lsb_msb;
    @(posedge clk) disable iff (!nrst)
      pix_valid |-> px1_blue[6] == lo_reg[0] && px1_blue[5] == lo_reg[7];
  endproperty
  a_lsb_msb: assert property (p_lsb_msb)
    else $error("lsb or msb on wrong lane bit");
  property p_edge_order;
    @(posedge clk) disable iff (!nrst)
      (rise && !edge_order) || (fall && edge_order)
        |=> lo_reg == $past(data_q);
  endproperty
  a_edge_order: assert property (p_edge_order)
    else $error("primary edge does not follow edge order");
  property p_pair_order;
    @(posedge clk) disable iff (!nrst)
      pix_valid |-> $past(sec_edge) && state_reg == ST_WAIT_PRI;
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("pixel presented without a secondary edge");
  property p_once;
    @(posedge clk) disable iff (!nrst)
      pix_valid |=> (!pix_valid) [*2];
  endproperty
  a_once: assert property (p_once)
    else $error("pixel presented twice in a period");
  c_one_port: cover property (@(posedge clk) pix_valid && !two_port_reg);
  c_two_port: cover property (@(posedge clk) pix_valid && two_port_reg);
  c_rise_first: cover property (@(posedge clk) pix_valid && !edge_order);
  c_fall_first: cover property (@(posedge clk) pix_valid && edge_order);
endmodule

// [bench/dpm_host_model.sv]
// host side: double-pumped pixel clock and data pins
// assumes the caller steps on falling edges of clk
`timescale 1ns/1ps
module dpm_host_model
  import dpm_pkg::*;
(
  input wire logic clk,
  output logic pixel_clk_in,
  output logic [IN_W-1:0] pixel_input_bits
);
  localparam int HALF = 4; // 100 ns half period
  initial begin
    pixel_clk_in = 1'b1;
    pixel_input_bits = 24'h00_0000;
  end
  // move the idle clock level; the edge taken here is a lone secondary
  // idle bus shows the inverse of its last word, so stale data cannot pass
  task automatic park(input logic eo);
    pixel_clk_in = eo;
    pixel_input_bits = ~pixel_input_bits;
    repeat (2 * HALF) @(negedge clk);
  endtask
  // one 200 ns host period: lower half, then upper half
  // caller stands on a falling edge of clk, so periods run back to back
  task automatic send(input logic [IN_W-1:0] lo, input logic [IN_W-1:0] hi);
    pixel_clk_in = ~pixel_clk_in;
    pixel_input_bits = lo;
    repeat (HALF) @(negedge clk);
    pixel_clk_in = ~pixel_clk_in;
    pixel_input_bits = hi;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// [bench/dpm_mapper_tb.sv]
// self-checking bench for the pixel mapper
// assumes the host model owns the pixel clock and data pins
`timescale 1ns/1ps
module dpm_mapper_tb;
  import dpm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic edge_order_pin = 1'b1;
  logic bus_width_setting = 1'b0;
  logic dc_balance_select = 1'b0;
  logic pixel_clk_in, dc_balance_out, pix_valid, prev_v;
  logic [IN_W-1:0] pixel_input_bits, lo, hi;
  logic [7:0] p1r, p1g, p1b, p2r, p2g, p2b, lane_enable;
  logic [56:0] e;
  logic [56:0] exp_q[$];
  logic [31:0] r;
  int fails = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  dpm_host_model host (.clk(clk), .pixel_clk_in(pixel_clk_in),
    .pixel_input_bits(pixel_input_bits));
  dpm_mapper dut (.clk(clk), .nrst(nrst), .pixel_clk_in(pixel_clk_in),
    .pixel_input_bits(pixel_input_bits), .edge_order_pin(edge_order_pin),
    .bus_width_setting(bus_width_setting),
    .dc_balance_select(dc_balance_select), .px1_red(p1r), .px1_green(p1g),
    .px1_blue(p1b), .px2_red(p2r), .px2_green(p2g), .px2_blue(p2b),
    .lane_enable(lane_enable), .dc_balance_out(dc_balance_out),
    .pix_valid(pix_valid));
  // colour bits to lane bits: 7..2 low, then lsb, then bit 1
  function automatic logic [7:0] lane(input logic [7:0] c);
    return {c[1], c[0], c[7:2]};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watcher: every pulse takes the oldest note
  always @(negedge clk) begin
    prev_v <= pix_valid;
    if (pix_valid === 1'b1) begin
      check(prev_v === 1'b1, 0);
      if (exp_q.size() == 0) begin
        check(1, 0);
      end else begin
        e = exp_q.pop_front();
        check(p1r, e[56:49]);
        check(p1g, e[48:41]);
        check(p1b, e[40:33]);
        check({p2r, p2g, p2b}, e[32:9]);
        check(lane_enable, e[8:1]);
        check(dc_balance_out, e[0]);
      end
    end
  end
  // main sequence; config changes every fourth pixel, else back to back
  initial begin
    r = $urandom(6);
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check({p1r, p1g, p1b, p2r, p2g, p2b, lane_enable, dc_balance_out,
      pix_valid}, {48'h0, 8'h0F, 2'b00});
    for (int i = 0; i < 32; i++) begin
      r = $urandom;
      if (i % 4 == 0) begin
        // walk all four edge-order and width pairs; balance stays random
        edge_order_pin = ~i[2];
        bus_width_setting = i[3];
        dc_balance_select = r[2];
        repeat (8) @(negedge clk);
        host.park(edge_order_pin);
      end
      lo = (i == 1) ? 24'hFF_FFFF : 24'($urandom);
      hi = (i == 1) ? 24'h00_0000 : 24'($urandom);
      exp_q.push_back({lane(hi[11:4]), lane({hi[3:0], lo[11:8]}),
        lane(lo[7:0]), bus_width_setting ? {lane(hi[23:16]),
        lane({hi[15:12], lo[23:20]}), lane(lo[19:12])} : 24'h0,
        bus_width_setting ? 8'hFF : 8'h0F, dc_balance_select});
      host.send(lo, hi);
    end
    repeat (20) @(negedge clk);
    check(exp_q.size(), 0);
    stop_test();
  end
  // about 415 cycles expected; the limit allows well over ten times that
  initial begin
    #200_000;
    fails++;
    stop_test();
  end
endmodule
